// [shared/sse_consts.vh]
// constants for the supply select and enable sequencer
`ifndef SSE_CONSTS_VH
`define SSE_CONSTS_VH

// register byte addresses
`define SSE_ADDR_CTRL 12'h000
`define SSE_ADDR_DET 12'h004
`define SSE_ADDR_STAT 12'h008

// control register fields
`define SSE_CTRL_AUXPRIO 0
`define SSE_CTRL_DETEN 1
`define SSE_CTRL_LDOSWEN 2
`define SSE_CTRL_LDOSWSEL 3
`define SSE_CTRL_CONVEN 4
`define SSE_CTRL_RESET 32'h00000010

// detector threshold fields
`define SSE_DET_RISE_LSB 0
`define SSE_DET_FALL_LSB 8
`define SSE_DET_RESET 32'h00000000

// status register fields
`define SSE_STAT_STANDBY 0
`define SSE_STAT_SELAUX 1
`define SSE_STAT_LOCKOK 2
`define SSE_STAT_HYST 3
`define SSE_STAT_CONV 4
`define SSE_STAT_LDOEN 5
`define SSE_STAT_GDFULL 6
`define SSE_STAT_TRIP 7

// lockout shutdown delay
`define SSE_CLK_MHZ 40
`define SSE_UVLO_DELAY_NS 10000
`define SSE_UVLO_DELAY_CYC ((`SSE_UVLO_DELAY_NS * `SSE_CLK_MHZ) / 1000)

`endif

// [core/sse_supply_sequencer.v]
// supply select, enable lockout and regulator sequencing logic
`timescale 1ns/10ps
//
// What this block does
// [R01] standby with bias once power-on and release pin high
// [R02] release pin low keeps device in shutdown
// [R03] both supplies above threshold: take lower one
// [R04] one supply below threshold: take the other
// [R05] both supplies below threshold: take higher one
// [R06] priority bit switches to forced auxiliary threshold
// [R07] priority mode, auxiliary below threshold: take input
// [R08] priority mode, auxiliary above threshold: take auxiliary
// [R09] lockout low for full delay stops converter
// [R10] hysteresis current on below enable rising threshold while lockout is below its rising threshold
// [R11] hysteresis current off above lockout rising threshold
// [R12] detector output gates converter operation directly
// [R13] detector thresholds from two separate fields
// [R14] detector disabled has no effect on converter
// [R15] software changes detector setup while converter off
// [R16] software disables detector, writes thresholds, re-enables
// [R17] auxiliary regulator starts on entering standby
// [R18] auxiliary regulator enable waits for resistor readout
// [R19] gate-driver regulator pre-bias once release pin high
// [R20] gate-driver regulator full once enable pin high
// [R21] comparator inputs pass two flip-flops first
`include "sse_consts.vh"

module sse_supply_sequencer
#(
   parameter UVLO_DELAY = `SSE_UVLO_DELAY_CYC,
   parameter THR_W = 8
)
(
   input wire clk,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // analog comparator outputs, asynchronous
   input wire powerOnAbove,
   input wire standbyReleaseAbove,
   input wire inputSupplyAboveSw,
   input wire auxSupplyAboveSw,
   input wire inputSupplyHigher,
   input wire auxSupplyAboveForced,
   input wire enableAboveEnRise,
   input wire lockoutAboveRise,
   input wire lockoutAboveFall,
   input wire detectorAbove,
   // resistor configuration readout, same clock
   input wire readoutDone,
   input wire readoutLdoEnable,
   // controls toward the analog side
   output reg biasActive,
   output reg standbyMode,
   output reg selectAuxSupply,
   output reg hystCurrentOn,
   output reg converterEnable,
   output reg detectorEnable,
   output reg [THR_W-1:0] detectorRise,
   output reg [THR_W-1:0] detectorFall,
   output reg auxLdoEnable,
   output reg gateLdoPreBias,
   output reg gateLdoFull
);

   localparam NSYNC = 10;
   localparam ST_SHUTDOWN = 1'b0;
   localparam ST_STANDBY = 1'b1;
   localparam CNT_W = 16;
   localparam [CNT_W-1:0] DELAY_LAST = UVLO_DELAY - 1;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   reg [NSYNC-1:0] syncA_r;
   reg [NSYNC-1:0] syncB_r;
   wire [NSYNC-1:0] rawIn;

   // bit order matches the named taps below
   assign rawIn = {
      detectorAbove,
      lockoutAboveFall,
      lockoutAboveRise,
      enableAboveEnRise,
      auxSupplyAboveForced,
      inputSupplyHigher,
      auxSupplyAboveSw,
      inputSupplyAboveSw,
      standbyReleaseAbove,
      powerOnAbove
   };

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         syncA_r <= {NSYNC{1'b0}};
         syncB_r <= {NSYNC{1'b0}};
      end
      else
      begin
         syncA_r <= rawIn; // [R21]
         syncB_r <= syncA_r; // [R21]
      end
   end

   wire porOk = syncB_r[0];
   wire relOk = syncB_r[1];
   wire vinSw = syncB_r[2];
   wire auxSw = syncB_r[3];
   wire vinHi = syncB_r[4];
   wire auxForce = syncB_r[5];
   wire enRise = syncB_r[6];
   wire uvRise = syncB_r[7];
   wire uvFall = syncB_r[8];
   wire detOk = syncB_r[9];

   ////////////////////////////////////////////////////////////////////////
   // apb register file

   reg [31:0] ctrl_r;
   reg [31:0] det_r;
   reg tripFlag_r;
   reg [CNT_W-1:0] lowCnt_r;
   reg lockOk_r;
   wire wrEn;
   wire rdEn;
   wire hitCtrl;
   wire hitDet;
   wire hitStat;
   wire tripEvent;
   wire [31:0] statWord;

   assign pready = 1'b1;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign hitCtrl = (paddr == `SSE_ADDR_CTRL);
   assign hitDet = (paddr == `SSE_ADDR_DET);
   assign hitStat = (paddr == `SSE_ADDR_STAT);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= `SSE_CTRL_RESET;
         det_r <= `SSE_DET_RESET;
      end
      else if (wrEn)
      begin
         if (hitCtrl)
            ctrl_r <= {27'h0000000, pwdata[4:0]};
         if (hitDet)
            det_r <= {16'h0000, pwdata[15:0]}; // [R13]
      end
   end

   wire auxPrio = ctrl_r[`SSE_CTRL_AUXPRIO];
   wire detEn = ctrl_r[`SSE_CTRL_DETEN];
   wire ldoSwEn = ctrl_r[`SSE_CTRL_LDOSWEN];
   wire ldoSwSel = ctrl_r[`SSE_CTRL_LDOSWSEL];
   wire convSwEn = ctrl_r[`SSE_CTRL_CONVEN];

   // sticky lockout trip, write one to clear, a new trip wins
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         tripFlag_r <= 1'b0;
      else if (tripEvent)
         tripFlag_r <= 1'b1;
      else if (wrEn && hitStat && pwdata[`SSE_STAT_TRIP])
         tripFlag_r <= 1'b0;
   end

   assign statWord = {24'h000000, tripFlag_r, gateLdoFull, auxLdoEnable,
      converterEnable, hystCurrentOn, lockOk_r, selectAuxSupply,
      standbyMode};

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel & ~penable)
         begin
            if (hitCtrl)
               prdata <= ctrl_r;
            else if (hitDet)
               prdata <= det_r;
            else if (hitStat)
               prdata <= statWord;
            else
               pslverr <= 1'b1;
         end
         else if (rdEn | wrEn)
         begin
            prdata <= prdata;
            pslverr <= pslverr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shutdown / standby

   reg state_r;
   reg state_nxt;

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_SHUTDOWN:
            if (porOk && relOk)
               state_nxt = ST_STANDBY; // [R01]
         ST_STANDBY:
            if (!porOk || !relOk)
               state_nxt = ST_SHUTDOWN; // [R02]
         default:
            state_nxt = ST_SHUTDOWN;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         state_r <= ST_SHUTDOWN;
      else
         state_r <= state_nxt;
   end

   wire inStandby = (state_r == ST_STANDBY);

   ////////////////////////////////////////////////////////////////////////
   // supply selection

   function selAux;
      input prio;
      input vAbove;
      input aAbove;
      input vHigher;
      input aForce;
      begin
         if (prio)
            selAux = aForce; // [R06] [R07] [R08]
         else if (vAbove && aAbove)
            selAux = vHigher; // [R03]
         else if (vAbove != aAbove)
            selAux = aAbove; // [R04]
         else
            selAux = ~vHigher; // [R05]
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // enable / lockout

   reg hyst_nxt;

   // dips shorter than the delay are ignored
   assign tripEvent = lockOk_r && !uvFall && (lowCnt_r == DELAY_LAST);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lowCnt_r <= {CNT_W{1'b0}};
         lockOk_r <= 1'b0;
      end
      else
      begin
         if (uvFall || !lockOk_r)
            lowCnt_r <= {CNT_W{1'b0}};
         else if (lowCnt_r != DELAY_LAST)
            lowCnt_r <= lowCnt_r + 1'b1; // [R09]
         if (tripEvent)
            lockOk_r <= 1'b0; // [R09]
         else if (enRise && uvRise)
            lockOk_r <= 1'b1;
      end
   end

   always @*
   begin
      hyst_nxt = hystCurrentOn;
      if (uvRise)
         hyst_nxt = 1'b0; // [R11]
      else if (!enRise)
         hyst_nxt = 1'b1; // [R10]
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs and regulator sequencing

   wire detGate = !detEn || detOk; // [R12] [R14]
   wire ldoSel = ldoSwSel ? ldoSwEn : readoutLdoEnable;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         biasActive <= 1'b0;
         standbyMode <= 1'b0;
         selectAuxSupply <= 1'b0;
         hystCurrentOn <= 1'b1;
         converterEnable <= 1'b0;
      end
      else
      begin
         biasActive <= inStandby; // [R01] [R02]
         standbyMode <= inStandby;
         selectAuxSupply <= selAux(auxPrio, vinSw, auxSw, vinHi, auxForce);
         hystCurrentOn <= hyst_nxt;
         // trip drops the enable at the same edge as the lockout clears
         converterEnable <= inStandby && lockOk_r && !tripEvent && detGate
            && convSwEn; // [R09] [R12]
      end
   end

   // detector setup copies toward the analog detector
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         detectorEnable <= 1'b0;
         detectorRise <= {THR_W{1'b0}};
         detectorFall <= {THR_W{1'b0}};
      end
      else
      begin
         detectorEnable <= detEn; // [R14]
         detectorRise <= det_r[`SSE_DET_RISE_LSB +: THR_W]; // [R13]
         detectorFall <= det_r[`SSE_DET_FALL_LSB +: THR_W]; // [R13]
      end
   end

   // regulator sequencing
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         auxLdoEnable <= 1'b0;
         gateLdoPreBias <= 1'b0;
         gateLdoFull <= 1'b0;
      end
      else
      begin
         auxLdoEnable <= inStandby && readoutDone && ldoSel; // [R17] [R18]
         gateLdoPreBias <= relOk && !enRise; // [R19]
         gateLdoFull <= relOk && enRise; // [R20]
      end
   end

endmodule

// [sim/sse_supply_model.sv]
// comparator model of the input and auxiliary supply pins
`timescale 1ns/10ps
module sse_supply_model
#(
   parameter SW = 8'h50,
   parameter FRC = 8'h30
)
(
   input wire [7:0] input_supply_pin,
   input wire [7:0] vaux,
   output wire [3:0] cmp
);
   // input above, aux above, input higher, aux above forced level
   assign cmp = {input_supply_pin > SW, vaux > SW, input_supply_pin > vaux, vaux > FRC};
endmodule

// [sim/sse_supply_sequencer_assertions.sv]
// port assertions for the supply sequencer
`timescale 1ns/10ps
module sse_supply_sequencer_assertions
(
   input wire clk,
   input wire rst,
   input wire powerOnAbove,
   input wire standbyReleaseAbove,
   input wire enableAboveEnRise,
   input wire lockoutAboveRise,
   input wire readoutDone,
   input wire biasActive,
   input wire standbyMode,
   input wire hystCurrentOn,
   input wire converterEnable,
   input wire auxLdoEnable,
   input wire gateLdoPreBias,
   input wire gateLdoFull
);
   reg [1:0] age_r;
   // edges since reset, sync chain full at 3
   always @(posedge clk or posedge rst)
      age_r <= rst ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   a_standby_entry: assert property (age_r == 2'h3 |-> standbyMode ==
      ($past(powerOnAbove, 4) && $past(standbyReleaseAbove, 4))) else $error("standby");
   a_bias_follow: assert property (biasActive == standbyMode) else $error("bias");
   a_gate_prebias: assert property (age_r == 2'h3 |-> gateLdoPreBias ==
      ($past(standbyReleaseAbove, 3) && !$past(enableAboveEnRise, 3))) else $error("prebias");
   a_gate_full: assert property (age_r == 2'h3 |-> gateLdoFull ==
      ($past(standbyReleaseAbove, 3) && $past(enableAboveEnRise, 3))) else $error("full");
   a_hyst_on: assert property (age_r == 2'h3 && !$past(enableAboveEnRise, 3)
      |-> hystCurrentOn) else $error("hyst on");
   a_hyst_off: assert property (age_r == 2'h3 && $past(lockoutAboveRise, 3)
      && $past(enableAboveEnRise, 3) |-> !hystCurrentOn) else $error("hyst off");
   a_ldo_gate: assert property (auxLdoEnable |-> $past(readoutDone)
      && (standbyMode || $past(standbyMode))) else $error("aux ldo");
   a_conv_standby: assert property (converterEnable |-> standbyMode
      || $past(standbyMode)) else $error("converter");
   c_trip: cover property (converterEnable ##1 !converterEnable);
   c_full: cover property (gateLdoFull && auxLdoEnable);
   c_hyst: cover property (hystCurrentOn ##1 !hystCurrentOn);
endmodule
bind sse_supply_sequencer sse_supply_sequencer_assertions u_chk (.clk(clk), .rst(rst),
   .powerOnAbove(powerOnAbove), .standbyReleaseAbove(standbyReleaseAbove),
   .enableAboveEnRise(enableAboveEnRise), .lockoutAboveRise(lockoutAboveRise),
   .readoutDone(readoutDone), .biasActive(biasActive), .standbyMode(standbyMode),
   .hystCurrentOn(hystCurrentOn), .converterEnable(converterEnable),
   .auxLdoEnable(auxLdoEnable), .gateLdoPreBias(gateLdoPreBias), .gateLdoFull(gateLdoFull));

// [sim/sse_supply_sequencer_bench.sv]
// self-checking bench for the supply sequencer
`timescale 1ns/10ps
`include "sse_consts.vh"
module sse_supply_sequencer_bench;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q;
   logic [7:0] ain = 8'h00, input_supply_pin = 8'h00, vaux = 8'h00;
   int err_count = 0, comparisons = 0;
   wire [31:0] prdata;
   wire [7:0] detectorRise, detectorFall;
   wire [3:0] cmp;
   wire pready, pslverr, biasActive, standbyMode, selectAuxSupply, hystCurrentOn;
   wire converterEnable, detectorEnable, auxLdoEnable, gateLdoPreBias, gateLdoFull;
   // priority, aux expected, input level, aux level
   logic [17:0] selTab [0:8] = '{18'h06070, 18'h17060, 18'h14090, 18'h09040, 18'h04020,
      18'h12040, 18'h26020, 18'h36040, 18'h36070};
   always #12.5 clk = ~clk;
   sse_supply_model sup (.input_supply_pin(input_supply_pin), .vaux(vaux), .cmp(cmp));
   sse_supply_sequencer #(.UVLO_DELAY(8)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .powerOnAbove(ain[7]), .standbyReleaseAbove(ain[6]),
      .inputSupplyAboveSw(cmp[3]), .auxSupplyAboveSw(cmp[2]), .inputSupplyHigher(cmp[1]),
      .auxSupplyAboveForced(cmp[0]), .enableAboveEnRise(ain[5]), .lockoutAboveRise(ain[4]),
      .lockoutAboveFall(ain[3]), .detectorAbove(ain[2]), .readoutDone(ain[1]),
      .readoutLdoEnable(ain[0]), .biasActive(biasActive), .standbyMode(standbyMode),
      .selectAuxSupply(selectAuxSupply), .hystCurrentOn(hystCurrentOn),
      .converterEnable(converterEnable), .detectorEnable(detectorEnable),
      .detectorRise(detectorRise), .detectorFall(detectorFall), .auxLdoEnable(auxLdoEnable),
      .gateLdoPreBias(gateLdoPreBias), .gateLdoFull(gateLdoFull));
   ////////////////////////////////////////
   task chk(input [39:0] g, input [39:0] x);
      comparisons++;
      if (g !== x)
      begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task put(input [7:0] v);
      @(posedge clk);
      ain <= v;
      wt(5);
   endtask
   // enable, lockout rise and fall drop together for n cycles
   task dip(input int n);
      put(8'hc3);
      wt(n - 6);
      put(8'hfb);
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      wt(2);
      chk({hystCurrentOn, standbyMode, converterEnable}, 3'h4);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(`SSE_ADDR_CTRL, 1'b0, 0);
      chk(q, `SSE_CTRL_RESET);
      apb(`SSE_ADDR_DET, 1'b0, 0);
      chk(q, `SSE_DET_RESET);
      apb(12'h00c, 1'b1, 32'hffffffff);
      chk({e, q}, 33'h100000000);
      put(8'h80);
      chk({standbyMode, gateLdoPreBias}, 2'h0);
      put(8'hc0);
      chk({biasActive, standbyMode, gateLdoPreBias, auxLdoEnable}, 4'he);
      put(8'hc3);
      chk(auxLdoEnable, 1'b1);
      apb(`SSE_ADDR_CTRL, 1'b1, 32'h18);
      wt(3);
      chk(auxLdoEnable, 1'b0);
      apb(`SSE_ADDR_CTRL, 1'b1, 32'h1c);
      wt(3);
      chk(auxLdoEnable, 1'b1);
      put(8'he3);
      chk({gateLdoPreBias, gateLdoFull, hystCurrentOn, converterEnable}, 4'h6);
      put(8'hfb);
      chk({hystCurrentOn, converterEnable}, 2'h1);
      foreach (selTab[i])
      begin
         apb(`SSE_ADDR_CTRL, 1'b1, {28'h1, 3'h0, selTab[i][17]});
         @(posedge clk);
         input_supply_pin <= selTab[i][15:8];
         vaux <= selTab[i][7:0];
         wt(5);
         chk(selectAuxSupply, selTab[i][16]);
      end
      dip(6);
      apb(`SSE_ADDR_STAT, 1'b0, 0);
      chk({q[`SSE_STAT_TRIP], converterEnable}, 2'h1);
      dip(19);
      apb(`SSE_ADDR_STAT, 1'b0, 0);
      chk(q[`SSE_STAT_TRIP], 1'b1);
      apb(`SSE_ADDR_CTRL, 1'b1, 32'h0);
      apb(`SSE_ADDR_DET, 1'b1, 32'h5a3c);
      apb(`SSE_ADDR_CTRL, 1'b1, 32'h12);
      wt(3);
      chk({detectorEnable, detectorFall, detectorRise}, 17'h15a3c);
      chk(converterEnable, 1'b0);
      put(8'hff);
      chk(converterEnable, 1'b1);
      put(8'hc7);
      chk({hystCurrentOn, gateLdoPreBias}, 2'h3);
      put(8'h07);
      chk({standbyMode, gateLdoPreBias, auxLdoEnable}, 3'h0);
      close_out;
   end
   initial
   begin
      #200000;
      err_count++;
      close_out;
   end
endmodule
